// ---- phy_select_pkg.sv ----
`default_nettype none

package phy_select_pkg;

    // Port counts
    localparam int unsigned NUM_ATTACH   = 3;  // Combined attach inputs, ports 0 to 2
    localparam int unsigned NUM_TC_PORTS = 2;  // Ports with two orientation PHYs, 1 and 2

    // Field positions inside the synchronised input word
    localparam int unsigned BIT_ATTACH = 0;   // Combined attach, 3 bits
    localparam int unsigned BIT_ORIENT_A = 3; // Orientation A attach, 2 bits
    localparam int unsigned BIT_ORIENT_B = 5; // Orientation B attach, 2 bits
    localparam int unsigned BIT_ORIENT = 7;   // Orientation, 2 bits
    localparam int unsigned BIT_POLARITY = 9; // Polarity strap
    localparam int unsigned BIT_SCHEME = 10;  // Scheme select
    localparam int unsigned SYNC_W = 11;      // Width of the synchronised word

    // Values after reset
    localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h000;  // Scheme 1, active high, nothing attached
    localparam logic              PHY_OFF    = 1'h0;     // PHY enable after reset

    // Cycles from an input pin to the PHY enable outputs
    localparam int unsigned SYNC_STAGES  = 2;
    localparam int unsigned PIPE_LATENCY = SYNC_STAGES + 1;
    localparam logic [1:0]  WARM_FULL    = 2'h3;  // Reset-free cycles before the pipe is full

    // Control scheme encoding of the select pin
    typedef enum logic {
        SCHEME_COMBINED = 1'b0,
        SCHEME_SPLIT    = 1'b1
    } ctrl_scheme_t;

endpackage

`default_nettype wire

// ---- sync_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface sync_bus_if;
    import phy_select_pkg::*;

    logic [SYNC_W-1:0] raw;     // Pin levels as they arrive
    logic [SYNC_W-1:0] synced;  // Same levels after two flip-flops

    modport sync_mp (input raw, output synced);
    modport user_mp (output raw, input synced);
endinterface

`default_nettype wire

// ---- input_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module input_sync
    import phy_select_pkg::*;
(
    input  wire logic    core_clk_in,  // Core clock, 10 MHz
    input  wire logic    reset_in,     // Asynchronous reset, active high
    sync_bus_if.sync_mp  bus           // Raw in, synchronised out
);

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d        = st_q;
        st_d.stage1 = bus.raw;
        st_d.stage2 = st_q.stage1;
    end

    // Reset lands on the pull-down defaults
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q <= '{stage1: SYNC_RESET, stage2: SYNC_RESET};  // R8 R9
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.synced = st_q.stage2;

endmodule

`default_nettype wire

// ---- typec_phy_attach_select.sv ----
// Function
// R1 - Select pin low: use combined attach and orientation inputs.
// R2 - Select pin high: use only per-orientation A and B attach inputs; port 0 still follows its combined attach input here.
// R3 - Scheme 2: active orientation A input turns on that port's PHY A.
// R4 - Scheme 2: active orientation B input turns on that port's PHY B; here PHY B stays off while the A input is also active.
// R5 - Scheme 2: inactive orientation input keeps its PHY off.
// R6 - Polarity strap low: all attach and orientation inputs active high.
// R7 - Polarity strap high: all attach and orientation inputs active low.
// R8 - Unconnected select pin defaults low, giving scheme 1.
// R9 - Unconnected polarity strap defaults low, giving active high inputs.
// R10 - Scheme 1: combined attach active turns the port PHY on, else off.
// R11 - Scheme 1: attached port takes PHY A if orientation active, else B.
// R12 - Inputs synchronised, enables updated each cycle, one PHY per port at most.
`timescale 1ns/1ps
`default_nettype none

module typec_phy_attach_select
    import phy_select_pkg::*;
(
    input  wire logic                    core_clk_in,            // Core clock, 10 MHz
    input  wire logic                    reset_in,               // Async reset, active high
    input  wire logic                    ctrl_scheme_select_in,  // Low scheme 1, high scheme 2
    input  wire logic                    attach_polarity_strap_in, // High: inputs active low
    input  wire logic [NUM_ATTACH-1:0]   port_attach_in,         // Combined attach, ports 0-2
    input  wire logic [NUM_TC_PORTS-1:0] port_orientation_in,    // Orientation, ports 1-2
    input  wire logic [NUM_TC_PORTS-1:0] orient_a_attach_in,     // Orientation A attach
    input  wire logic [NUM_TC_PORTS-1:0] orient_b_attach_in,     // Orientation B attach
    output logic                         port0_phy_en_out,       // Port 0 PHY enable
    output logic      [NUM_TC_PORTS-1:0] phy_a_en_out,           // PHY A enable, ports 1-2
    output logic      [NUM_TC_PORTS-1:0] phy_b_en_out            // PHY B enable, ports 1-2
);

    // Registered enables and a saturating count of reset-free edges
    typedef struct packed {
        logic                    port0_en;
        logic [NUM_TC_PORTS-1:0] phy_a_en;
        logic [NUM_TC_PORTS-1:0] phy_b_en;
        logic [1:0]              warm;   // Cycles since reset, saturating
    } sel_state_t;

    sel_state_t st_q;
    sel_state_t st_d;

    sync_bus_if sbus ();

    // Pack every pin into one word for the synchroniser
    assign sbus.raw = {ctrl_scheme_select_in, attach_polarity_strap_in, port_orientation_in,
                       orient_b_attach_in, orient_a_attach_in, port_attach_in};  // R12

    // Two flip-flops per pin; all pins cross together
    input_sync u_sync (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .bus         (sbus.sync_mp)
    );

    // Synchronised fields
    logic                    scheme_s;
    logic                    polarity_s;
    logic [NUM_ATTACH-1:0]   attach_s;
    logic [NUM_TC_PORTS-1:0] orient_s;
    logic [NUM_TC_PORTS-1:0] orient_a_s;
    logic [NUM_TC_PORTS-1:0] orient_b_s;

    assign scheme_s   = sbus.synced[BIT_SCHEME];
    assign polarity_s = sbus.synced[BIT_POLARITY];
    assign attach_s   = sbus.synced[BIT_ATTACH +: NUM_ATTACH];
    assign orient_s   = sbus.synced[BIT_ORIENT +: NUM_TC_PORTS];
    assign orient_a_s = sbus.synced[BIT_ORIENT_A +: NUM_TC_PORTS];
    assign orient_b_s = sbus.synced[BIT_ORIENT_B +: NUM_TC_PORTS];

    // Inputs in true sense: strap high flips every attach and orientation bit
    logic [NUM_ATTACH-1:0]   attach_t;
    logic [NUM_TC_PORTS-1:0] orient_t;
    logic [NUM_TC_PORTS-1:0] orient_a_t;
    logic [NUM_TC_PORTS-1:0] orient_b_t;

    assign attach_t   = polarity_s ? ~attach_s   : attach_s;    // R6 R7
    assign orient_t   = polarity_s ? ~orient_s   : orient_s;    // R6 R7
    assign orient_a_t = polarity_s ? ~orient_a_s : orient_a_s;  // R6 R7
    assign orient_b_t = polarity_s ? ~orient_b_s : orient_b_s;  // R6 R7

    // Next enables, recomputed every cycle
    always_comb begin
        st_d          = st_q;
        // Port 0 has one PHY and follows its attach input in both schemes
        st_d.port0_en = attach_t[0];  // R10
        if (st_q.warm != WARM_FULL) begin
            st_d.warm = st_q.warm + 2'h1;
        end
        // One pass per port with two orientation PHYs
        for (int i = 0; i < NUM_TC_PORTS; i++) begin
            if (ctrl_scheme_t'(scheme_s) == SCHEME_COMBINED) begin
                // Attach gates the port, orientation picks A or B
                st_d.phy_a_en[i] = attach_t[i+1] & orient_t[i];   // R1 R10 R11
                st_d.phy_b_en[i] = attach_t[i+1] & ~orient_t[i];  // R1 R10 R11
            end else begin
                // A wins if the detector claims both orientations
                st_d.phy_a_en[i] = orient_a_t[i];                  // R2 R3 R5
                st_d.phy_b_en[i] = orient_b_t[i] & ~orient_a_t[i]; // R2 R4 R5 R12
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q <= '{port0_en: PHY_OFF, phy_a_en: '0, phy_b_en: '0, warm: 2'h0};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign port0_phy_en_out = st_q.port0_en;
    assign phy_a_en_out     = st_q.phy_a_en;
    assign phy_b_en_out     = st_q.phy_b_en;

    // Pipe full once three reset-free edges have passed
    // Checks look three edges back, so they wait until the pipe holds real pins
    logic warm_full;
    assign warm_full = (st_q.warm == WARM_FULL);

    // Checks on the pin-to-enable path, three cycles deep
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // Scheme 1: combined attach gates the port, orientation picks the PHY
    a_scheme1_port0: assert property (warm_full |->         // R10
        port0_phy_en_out == ($past(port_attach_in[0], 3) ^ $past(attach_polarity_strap_in, 3)))
        else $error("Port 0 PHY enable does not follow its attach input");

    a_scheme1_port_a: assert property ((warm_full && !$past(ctrl_scheme_select_in, 3)) |->  // R1
        phy_a_en_out == (($past(port_attach_in[2:1], 3)
                           ^ {2{$past(attach_polarity_strap_in, 3)}})
                         & ($past(port_orientation_in, 3)
                           ^ {2{$past(attach_polarity_strap_in, 3)}})))
        else $error("Scheme 1 PHY A enable wrong");

    a_scheme1_orient_b: assert property (                                             // R11
        (warm_full && !$past(ctrl_scheme_select_in, 3) && !$past(attach_polarity_strap_in, 3))
        |-> phy_b_en_out == ($past(port_attach_in[2:1], 3) & ~$past(port_orientation_in, 3)))
        else $error("Scheme 1 PHY B enable wrong with active high inputs");

    a_scheme1_b_inv: assert property (                                                // R11
        (warm_full && !$past(ctrl_scheme_select_in, 3) && $past(attach_polarity_strap_in, 3))
        |-> phy_b_en_out == (~$past(port_attach_in[2:1], 3) & $past(port_orientation_in, 3)))
        else $error("Scheme 1 PHY B enable wrong with active low inputs");

    a_scheme1_off_idle: assert property (                                             // R10
        (warm_full && !$past(ctrl_scheme_select_in, 3)
         && ($past(port_attach_in[2:1], 3) == {2{$past(attach_polarity_strap_in, 3)}}))
        |-> (phy_a_en_out == 2'h0) && (phy_b_en_out == 2'h0))
        else $error("Scheme 1 PHY left on with attach inputs inactive");

    // Scheme 2: each orientation input drives its own PHY
    a_scheme2_port_a: assert property ((warm_full && $past(ctrl_scheme_select_in, 3)) |->  // R3
        phy_a_en_out == ($past(orient_a_attach_in, 3) ^ {2{$past(attach_polarity_strap_in, 3)}}))
        else $error("Scheme 2 PHY A enable does not follow orientation A input");

    a_scheme2_port_b: assert property (                                               // R4
        (warm_full && $past(ctrl_scheme_select_in, 3) && !$past(attach_polarity_strap_in, 3))
        |-> phy_b_en_out == ($past(orient_b_attach_in, 3) & ~$past(orient_a_attach_in, 3)))
        else $error("Scheme 2 PHY B enable does not follow orientation B input");

    a_scheme2_b_inv: assert property (                                                // R4
        (warm_full && $past(ctrl_scheme_select_in, 3) && $past(attach_polarity_strap_in, 3))
        |-> phy_b_en_out == (~$past(orient_b_attach_in, 3) & $past(orient_a_attach_in, 3)))
        else $error("Scheme 2 PHY B enable wrong with active low inputs");

    a_scheme2_off_idle: assert property (                                             // R5
        (warm_full && $past(ctrl_scheme_select_in, 3) && $past(attach_polarity_strap_in, 3)
         && ($past(orient_a_attach_in, 3) == 2'h3) && ($past(orient_b_attach_in, 3) == 2'h3))
        |-> (phy_a_en_out == 2'h0) && (phy_b_en_out == 2'h0))
        else $error("Scheme 2 PHY left on with inputs inactive");

    a_scheme2_ignores: assert property (                                              // R2
        (ctrl_scheme_select_in && $stable(ctrl_scheme_select_in)
         && $stable(attach_polarity_strap_in) && $stable(orient_a_attach_in)
         && $stable(orient_b_attach_in) && warm_full)
        ##3 warm_full |-> $stable(phy_a_en_out) && $stable(phy_b_en_out))
        else $error("Scheme 2 enables moved with their inputs held");

    // Strap sense, one PHY per port, pin holding and reset defaults
    a_polarity_low: assert property (                                                 // R6
        (warm_full && !$past(attach_polarity_strap_in, 3) && !$past(ctrl_scheme_select_in, 3)
         && ($past(port_attach_in, 3) == 3'h0))
        |-> !port0_phy_en_out && (phy_a_en_out == 2'h0) && (phy_b_en_out == 2'h0))
        else $error("PHY on with active high attach inputs all low");

    a_polarity_high: assert property (                                                // R7
        (warm_full && $past(attach_polarity_strap_in, 3) && $past(ctrl_scheme_select_in, 3)
         && ($past(orient_a_attach_in, 3) == 2'h0))
        |-> (phy_a_en_out == 2'h3) && (phy_b_en_out == 2'h0))
        else $error("Low orientation A input did not enable PHY A under high strap");

    a_one_phy_port: assert property (                                                 // R12
        (phy_a_en_out & phy_b_en_out) == 2'h0)
        else $error("Both PHYs of one port enabled");

    a_enables_hold: assert property (                                                 // R12
        (warm_full && $past(warm_full) && ($past(sbus.raw, 3) == $past(sbus.raw, 4)))
        |-> $stable(port0_phy_en_out) && $stable(phy_a_en_out) && $stable(phy_b_en_out))
        else $error("PHY enables moved with their pins held");

    a_reset_defaults: assert property (                                               // R8
        ($rose(warm_full) && !$past(ctrl_scheme_select_in, 3)
         && !$past(attach_polarity_strap_in, 3) && ($past(port_attach_in, 3) == 3'h7)
         && ($past(port_orientation_in, 3) == 2'h3))
        |-> port0_phy_en_out && (phy_a_en_out == 2'h3))
        else $error("Low straps did not give scheme 1 with active high inputs");

    a_reset_off: assert property (@(posedge core_clk_in)                              // R9
        $fell(reset_in) |-> !port0_phy_en_out && (phy_a_en_out == 2'h0)
                            && (phy_b_en_out == 2'h0))
        else $error("PHY enabled straight out of reset");

    // Main scenarios to be seen at least once
    c_scheme1_a: cover property (warm_full && !ctrl_scheme_select_in && (phy_a_en_out != 2'h0));
    c_scheme2_a: cover property (warm_full && ctrl_scheme_select_in && (phy_a_en_out != 2'h0));
    c_scheme1_b: cover property (warm_full && !ctrl_scheme_select_in && (phy_b_en_out != 2'h0));
    c_scheme2_b: cover property (warm_full && ctrl_scheme_select_in && (phy_b_en_out != 2'h0));
    c_inverted:  cover property (warm_full && attach_polarity_strap_in && port0_phy_en_out);

endmodule

`default_nettype wire

// ---- attach_detector_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module attach_detector_model
    import phy_select_pkg::*;
(
    input  wire logic                    polarity_in,    // Board polarity strap level
    input  wire logic [NUM_ATTACH-1:0]   attach_in,      // True attach state per port
    input  wire logic [NUM_TC_PORTS-1:0] orient_in,      // True orientation, 1 = side A
    input  wire logic [NUM_TC_PORTS-1:0] side_a_in,      // True side A attach
    input  wire logic [NUM_TC_PORTS-1:0] side_b_in,      // True side B attach
    output logic      [NUM_ATTACH-1:0]   attach_pin_out, // Combined attach pins
    output logic      [NUM_TC_PORTS-1:0] orient_pin_out, // Orientation pins
    output logic      [NUM_TC_PORTS-1:0] side_a_pin_out, // Side A attach pins
    output logic      [NUM_TC_PORTS-1:0] side_b_pin_out  // Side B attach pins
);
    // Pins follow the sense that the board strap selects
    assign attach_pin_out = attach_in ^ {NUM_ATTACH{polarity_in}};
    assign orient_pin_out = orient_in ^ {NUM_TC_PORTS{polarity_in}};
    assign side_a_pin_out = side_a_in ^ {NUM_TC_PORTS{polarity_in}};
    assign side_b_pin_out = side_b_in ^ {NUM_TC_PORTS{polarity_in}};
endmodule

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import phy_select_pkg::*;

    logic        core_clk_in = 1'h0;
    logic        reset_in;
    logic        scheme;
    logic        pol;
    logic [2:0]  att;
    logic [1:0]  ori;
    logic [1:0]  a_att;
    logic [1:0]  b_att;
    logic [2:0]  att_pin;
    logic [1:0]  ori_pin;
    logic [1:0]  a_pin;
    logic [1:0]  b_pin;
    logic        port0;
    logic [1:0]  phy_a;
    logic [1:0]  phy_b;
    logic [31:0] seed;
    logic [10:0] corner [6];
    int          n_mismatch;
    int          tests_run;

    // Clock, 100 ns period
    always #50 core_clk_in = ~core_clk_in;

    attach_detector_model u_attach_detector_model (
        .polarity_in    (pol),
        .attach_in      (att),
        .orient_in      (ori),
        .side_a_in      (a_att),
        .side_b_in      (b_att),
        .attach_pin_out (att_pin),
        .orient_pin_out (ori_pin),
        .side_a_pin_out (a_pin),
        .side_b_pin_out (b_pin)
    );

    typec_phy_attach_select u_typec_phy_attach_select (
        .core_clk_in              (core_clk_in),
        .reset_in                 (reset_in),
        .ctrl_scheme_select_in    (scheme),
        .attach_polarity_strap_in (pol),
        .port_attach_in           (att_pin),
        .port_orientation_in      (ori_pin),
        .orient_a_attach_in       (a_pin),
        .orient_b_attach_in       (b_pin),
        .port0_phy_en_out         (port0),
        .phy_a_en_out             (phy_a),
        .phy_b_en_out             (phy_b)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected enables {B, A, port 0} from the true input state
    function automatic logic [4:0] expect_phy();
        logic [1:0] pa;
        logic [1:0] pb;
        if (scheme) begin
            pa = a_att;
            pb = b_att & ~a_att;
        end else begin
            pa = att[2:1] & ori;
            pb = att[2:1] & ~ori;
        end
        return {pb, pa, att[0]};
    endfunction

    task automatic check(input logic [4:0] exp);
        tests_run++;
        if ({phy_b, phy_a, port0} !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, {phy_b, phy_a, port0}, exp);
        end
    endtask

    // Apply a new state, old result must hold two edges, new one lands at the third
    task automatic step(input logic [10:0] v);
        logic [4:0] old_exp;
        old_exp = expect_phy();
        {scheme, pol, ori, b_att, a_att, att} = v;
        repeat (2) @(posedge core_clk_in);
        #1 check(old_exp);
        @(posedge core_clk_in);
        #1 check(expect_phy());
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset with live pins, then corner cases, then random states
    initial begin
        n_mismatch = 0;
        tests_run  = 0;
        seed       = 32'h0000_98a3;
        reset_in   = 1'h1;
        {scheme, pol, ori, b_att, a_att, att} = 11'h187;
        corner = '{11'h478, 11'h648, 11'h087, 11'h379, 11'h587, 11'h200};
        repeat (6) @(posedge core_clk_in);
        #1 check(5'h00);
        reset_in = 1'h0;
        @(posedge core_clk_in);
        #1 check(5'h00);
        repeat (2) @(posedge core_clk_in);
        #1 check(expect_phy());
        foreach (corner[i]) begin
            step(corner[i]);
        end
        repeat (60) begin
            seed = xorshift(seed);
            step(seed[10:0]);
        end
        print_verdict();
    end
endmodule

`default_nettype wire
